/* File: hdl/temp_alarm_pkg.sv */
// Constants, register map and carrier types of the temperature alarm block
package temp_alarm_pkg;

	// ----------------------------------------------------------------
	// Register map (byte offsets on the local register port)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_LOCAL_VALUE = 8'h00;
	localparam logic [7:0] REG_REMOTE_VALUE = 8'h01;
	localparam logic [7:0] REG_STATUS = 8'h02;
	localparam logic [7:0] REG_CONFIG = 8'h03;
	localparam logic [7:0] REG_LOCAL_HIGH = 8'h04;
	localparam logic [7:0] REG_LOCAL_LOW = 8'h05;
	localparam logic [7:0] REG_REMOTE_HIGH = 8'h06;
	localparam logic [7:0] REG_REMOTE_LOW = 8'h07;
	localparam logic [7:0] REG_ONE_SHOT = 8'h0F;
	localparam logic [7:0] REG_REMOTE_OT_LIMIT = 8'h10;
	localparam logic [7:0] REG_LOCAL_OT_LIMIT = 8'h11;
	localparam logic [7:0] REG_OT_HYST = 8'h12;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CFG_ALARM_MASK_BIT = 7;
	localparam int CFG_STANDBY_BIT = 6;
	localparam int CFG_PIN_OT2_BIT = 5;
	localparam int ST_BUSY_BIT = 7;
	localparam int ST_OPEN_BIT = 2;

	// ----------------------------------------------------------------
	// Values after reset
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_CONFIG = 8'h00;
	localparam logic [7:0] RST_HIGH_LIMIT = 8'h55;
	localparam logic [7:0] RST_LOW_LIMIT = 8'h00;
	localparam logic [7:0] RST_OT_LIMIT = 8'h55;
	localparam logic [7:0] RST_OT_HYST = 8'h0A;
	localparam logic [7:0] RST_VALUE = 8'h00;

	// ----------------------------------------------------------------
	// Serial addresses
	// ----------------------------------------------------------------
	localparam logic [6:0] ALERT_RESPONSE_ADDR = 7'h0C;
	localparam logic [6:0] OWN_ADDR = 7'h4C;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 250;
	localparam int CONV_INTERVAL_MS = 16;
	localparam int CONV_INTERVAL_CYC = CONV_INTERVAL_MS * 1000 * CLK_MHZ;
	localparam int SYNC_STAGES = 3;

	// Channel index
	localparam logic CH_LOCAL = 1'b0;
	localparam logic CH_REMOTE = 1'b1;

	// Result handed back by the converter
	typedef struct packed {
		logic done;
		logic chan;
		logic [7:0] value;
	} adc_result_type;

	// Request to the converter
	typedef struct packed {
		logic start;
		logic abort;
		logic chan;
	} adc_request_type;

	// Register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_request_type;

endpackage

/* File: hdl/pin_sync.sv */
// Three-stage synchroniser with agreement filter for asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Asynchronous inputs and filtered result
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] stable_q
);

	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	logic [WIDTH-1:0] stable_d;

	// A change is taken once stages two and three agree
	always_comb begin
		stable_d = stable_q;
		for (int i = 0; i < WIDTH; i++) begin
			if (s2_q[i] == s3_q[i]) begin
				stable_d[i] = s3_q[i];
			end
		end
	end

	// Pipeline; stage one feeds only stage two
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			s1_q <= '1;
			s2_q <= '1;
			s3_q <= '1;
			stable_q <= '1;
		end else begin
			s1_q <= async_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			stable_q <= stable_d;
		end
	end

endmodule
`default_nettype wire

/* File: hdl/alert_responder.sv */
// Serial-bus responder that answers only the alert response address
`timescale 1ns/1ps
`default_nettype none
module alert_responder (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Filtered bus levels
	input wire logic scl_s,
	input wire logic sda_s,
	// Alarm state
	input wire logic alert_active,
	// Bus data drive and completion
	output logic sda_oe_q,
	output logic serviced_q
);

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_ACK = 3'b010,
		ST_SEND = 3'b011,
		ST_MACK = 3'b100
	} resp_state_type;

	resp_state_type state_q, state_d;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] sh_q, sh_d;
	logic sda_oe_d;
	logic serviced_d;
	logic scl_prev_q;
	logic sda_prev_q;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;

	// Edge and bus condition detection on filtered levels
	assign scl_rise = scl_s & ~scl_prev_q;
	assign scl_fall = ~scl_s & scl_prev_q;
	assign start_cond = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
	assign stop_cond = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

	// Next state
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		sda_oe_d = sda_oe_q;
		serviced_d = 1'b0;
		if (start_cond) begin
			state_d = ST_ADDR;
			cnt_d = 4'h0;
			sda_oe_d = 1'b0;
		end else if (stop_cond) begin
			state_d = ST_IDLE;
			sda_oe_d = 1'b0;
		end else begin
			case (state_q)
				ST_ADDR: begin
					if (scl_rise && cnt_q != 4'h8) begin
						sh_d = {sh_q[6:0], sda_s};
						cnt_d = cnt_q + 4'h1;
					end else if (scl_fall && cnt_q == 4'h8) begin
						// Read to the response address while our alarm is low
						if (sh_q == {temp_alarm_pkg::ALERT_RESPONSE_ADDR, 1'b1}
								&& alert_active) begin
							state_d = ST_ACK;
							sda_oe_d = 1'b1;
						end else begin
							state_d = ST_IDLE;
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						// Own address with a one in the lowest bit
						sh_d = {temp_alarm_pkg::OWN_ADDR, 1'b1};
						sda_oe_d = ~temp_alarm_pkg::OWN_ADDR[6];
						cnt_d = 4'h0;
						state_d = ST_SEND;
					end
				end
				ST_SEND: begin
					if (scl_rise) begin
						// Released bit read back low: a lower address wins
						if (sh_q[7] && !sda_s) begin
							sda_oe_d = 1'b0;
							state_d = ST_IDLE;
						end else begin
							cnt_d = cnt_q + 4'h1;
						end
					end else if (scl_fall) begin
						if (cnt_q == 4'h8) begin
							sda_oe_d = 1'b0;
							state_d = ST_MACK;
						end else begin
							sh_d = {sh_q[6:0], 1'b0};
							sda_oe_d = ~sh_q[6];
						end
					end
				end
				ST_MACK: begin
					if (scl_rise) begin
						serviced_d = 1'b1;
						state_d = ST_IDLE;
					end
				end
				default: begin
					state_d = ST_IDLE;
				end
			endcase
		end
	end

	// State registers
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			state_q <= ST_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			sda_oe_q <= 1'b0;
			serviced_q <= 1'b0;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			sda_oe_q <= sda_oe_d;
			serviced_q <= serviced_d;
			scl_prev_q <= scl_s;
			sda_prev_q <= sda_s;
		end
	end

endmodule
`default_nettype wire

/* File: hdl/temp_alarm_interrupt_logic.sv */
// Limit comparison, alarm and overtemperature outputs of a temperature monitor
`timescale 1ns/1ps
`default_nettype none
module temp_alarm_interrupt_logic #(
	parameter int CONV_INTERVAL = temp_alarm_pkg::CONV_INTERVAL_CYC
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Register port
	input wire temp_alarm_pkg::reg_request_type reg_req,
	output logic [7:0] reg_rdata_q,
	// Converter
	output temp_alarm_pkg::adc_request_type adc_req_q,
	input wire temp_alarm_pkg::adc_result_type adc_res,
	input wire logic open_cmp_i,
	// Serial bus
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	// Open-drain alarm pin and overtemperature pin
	output logic alarm_o,
	output logic alarm_oe_q,
	output logic overtemp_out_o,
	output logic overtemp_out_oe_q
);

	// ----------------------------------------------------------------
	// Pin synchronisers and responder
	// ----------------------------------------------------------------
	logic [2:0] pins_s;
	logic serviced;
	logic sda_drive_q;

	pin_sync #(
		.WIDTH(3)
	) u_sync (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.async_i({open_cmp_i, sda_i, scl_i}),
		.stable_q(pins_s)
	);

	alert_responder u_resp (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.scl_s(pins_s[0]),
		.sda_s(pins_s[1]),
		.alert_active(alarm_oe_q),
		.sda_oe_q(sda_drive_q),
		.serviced_q(serviced)
	);

	// Open-drain lines only ever drive a low level
	assign sda_o = 1'b0;
	assign sda_oe = sda_drive_q;
	assign alarm_o = 1'b0;
	assign overtemp_out_o = 1'b0;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CV_IDLE = 2'b00,
		CV_LOCAL = 2'b01,
		CV_REMOTE = 2'b10
	} conv_state_type;

	logic [7:0] config_q, config_d;
	logic [7:0] value_q [2], value_d [2];
	logic [7:0] high_q [2], high_d [2];
	logic [7:0] low_q [2], low_d [2];
	logic [7:0] ot_lim_q [2], ot_lim_d [2];
	logic [7:0] hyst_q, hyst_d;
	logic [6:0] status_q, status_d;
	logic [4:0] cond_q, cond_d;
	logic [1:0] ot_q, ot_d;
	logic [1:0] ot2_q, ot2_d;
	logic open_q, open_d;
	logic alert_q, alert_d;
	logic serviced_q, serviced_d;
	logic oneshot_q, oneshot_d;
	logic eval_q, eval_d;
	logic [31:0] timer_q, timer_d;
	conv_state_type cv_q, cv_d;
	temp_alarm_pkg::adc_request_type adc_req_d;
	logic [7:0] rdata_d;
	logic alarm_oe_d;
	logic overtemp_out_oe_d;
	logic standby;
	logic wr_limit;
	logic [4:0] cond_now;
	logic [7:0] release_lvl [2];
	logic [7:0] release2_lvl [2];

	assign standby = config_q[temp_alarm_pkg::CFG_STANDBY_BIT];
	assign wr_limit = reg_req.wr && (reg_req.addr == temp_alarm_pkg::REG_LOCAL_HIGH
		|| reg_req.addr == temp_alarm_pkg::REG_LOCAL_LOW
		|| reg_req.addr == temp_alarm_pkg::REG_REMOTE_HIGH
		|| reg_req.addr == temp_alarm_pkg::REG_REMOTE_LOW);

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	// Software-written settings
	always_comb begin
		config_d = config_q;
		high_d = high_q;
		low_d = low_q;
		ot_lim_d = ot_lim_q;
		hyst_d = hyst_q;
		if (reg_req.wr) begin
			case (reg_req.addr)
				temp_alarm_pkg::REG_CONFIG: config_d = reg_req.wdata;
				temp_alarm_pkg::REG_LOCAL_HIGH: high_d[0] = reg_req.wdata;
				temp_alarm_pkg::REG_LOCAL_LOW: low_d[0] = reg_req.wdata;
				temp_alarm_pkg::REG_REMOTE_HIGH: high_d[1] = reg_req.wdata;
				temp_alarm_pkg::REG_REMOTE_LOW: low_d[1] = reg_req.wdata;
				temp_alarm_pkg::REG_REMOTE_OT_LIMIT: ot_lim_d[1] = reg_req.wdata;
				temp_alarm_pkg::REG_LOCAL_OT_LIMIT: ot_lim_d[0] = reg_req.wdata;
				temp_alarm_pkg::REG_OT_HYST: hyst_d = reg_req.wdata;
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Conversion sequencer
	// ----------------------------------------------------------------
	// Local first, then remote; the result lands only if not aborted
	always_comb begin
		cv_d = cv_q;
		value_d = value_q;
		timer_d = timer_q;
		open_d = open_q;
		eval_d = 1'b0;
		adc_req_d = '0;
		oneshot_d = oneshot_q;
		// Data written to the one-shot location is ignored
		if (reg_req.wr && reg_req.addr == temp_alarm_pkg::REG_ONE_SHOT && standby) begin
			oneshot_d = 1'b1;
		end
		if (!standby && timer_q != 32'h0) begin
			timer_d = timer_q - 32'h1;
		end
		case (cv_q)
			CV_IDLE: begin
				if ((!standby && timer_q == 32'h0) || oneshot_q) begin
					timer_d = 32'(CONV_INTERVAL - 1);
					cv_d = CV_LOCAL;
					adc_req_d.start = 1'b1;
					adc_req_d.chan = temp_alarm_pkg::CH_LOCAL;
				end
			end
			CV_LOCAL, CV_REMOTE: begin
				if (standby && !oneshot_q) begin
					// Standby aborts without touching the value register
					cv_d = CV_IDLE;
					adc_req_d.abort = 1'b1;
				end else if (adc_res.done && adc_res.chan == (cv_q == CV_REMOTE)) begin
					if (cv_q == CV_LOCAL) begin
						value_d[0] = adc_res.value;
						cv_d = CV_REMOTE;
						adc_req_d.start = 1'b1;
						adc_req_d.chan = temp_alarm_pkg::CH_REMOTE;
						// Comparator taken as the remote conversion begins
						open_d = pins_s[2];
					end else begin
						value_d[1] = adc_res.value;
						cv_d = CV_IDLE;
						oneshot_d = 1'b0;
						eval_d = 1'b1;
					end
				end
			end
			default: begin
				cv_d = CV_IDLE;
			end
		endcase
		// High and low limits changed in standby are checked against stored values
		if (wr_limit && standby) begin
			eval_d = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Comparisons
	// ----------------------------------------------------------------
	// Above high, or at or below low, per channel, plus open sensor
	assign cond_now = {value_q[0] > high_q[0], value_q[0] <= low_q[0],
		value_q[1] > high_q[1], value_q[1] <= low_q[1], open_q};

	// Release levels saturate at zero when hysteresis exceeds the limit
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			release_lvl[i] = (ot_lim_q[i] > hyst_q) ? ot_lim_q[i] - hyst_q : 8'h00;
			release2_lvl[i] = (high_q[i] > hyst_q) ? high_q[i] - hyst_q : 8'h00;
		end
	end

	// Overtemperature states with hysteresis, evaluated after conversions
	always_comb begin
		ot_d = ot_q;
		ot2_d = ot2_q;
		cond_d = cond_q;
		if (eval_q) begin
			cond_d = cond_now;
			for (int i = 0; i < 2; i++) begin
				if (value_q[i] > ot_lim_q[i]) begin
					ot_d[i] = 1'b1;
				end else if (value_q[i] <= release_lvl[i]) begin
					ot_d[i] = 1'b0;
				end
				if (value_q[i] > high_q[i]) begin
					ot2_d[i] = 1'b1;
				end else if (value_q[i] <= release2_lvl[i]) begin
					ot2_d[i] = 1'b0;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Status, alarm latch and read port
	// ----------------------------------------------------------------
	// Status clears on read; a new event in the same cycle wins
	always_comb begin
		status_d = status_q;
		if (reg_req.rd && reg_req.addr == temp_alarm_pkg::REG_STATUS) begin
			status_d = 7'h00;
		end
		if (eval_q) begin
			status_d = status_d | {cond_now, ot_d[1], ot_d[0]};
		end
	end

	// Alarm latch: held until serviced, cause gone and status cleared
	always_comb begin
		alert_d = alert_q;
		serviced_d = serviced_q | serviced;
		if (eval_q && |cond_now) begin
			alert_d = 1'b1;
			serviced_d = 1'b0;
		end else if (serviced_q && cond_q == 5'h00 && status_q[6:2] == 5'h00) begin
			alert_d = 1'b0;
			serviced_d = 1'b0;
		end
	end

	// Pin drive: mask gates only the alarm role, overtemp has no mask
	always_comb begin
		if (config_q[temp_alarm_pkg::CFG_PIN_OT2_BIT]) begin
			alarm_oe_d = |ot2_q;
		end else begin
			alarm_oe_d = alert_q & ~config_q[temp_alarm_pkg::CFG_ALARM_MASK_BIT];
		end
		overtemp_out_oe_d = |ot_q;
	end

	// Read data one cycle after the strobe; unmapped reads give zero
	always_comb begin
		rdata_d = 8'h00;
		if (reg_req.rd) begin
			case (reg_req.addr)
				temp_alarm_pkg::REG_LOCAL_VALUE: rdata_d = value_q[0];
				temp_alarm_pkg::REG_REMOTE_VALUE: rdata_d = value_q[1];
				temp_alarm_pkg::REG_STATUS: rdata_d = {cv_q != CV_IDLE, status_q};
				temp_alarm_pkg::REG_CONFIG: rdata_d = config_q;
				temp_alarm_pkg::REG_LOCAL_HIGH: rdata_d = high_q[0];
				temp_alarm_pkg::REG_LOCAL_LOW: rdata_d = low_q[0];
				temp_alarm_pkg::REG_REMOTE_HIGH: rdata_d = high_q[1];
				temp_alarm_pkg::REG_REMOTE_LOW: rdata_d = low_q[1];
				temp_alarm_pkg::REG_REMOTE_OT_LIMIT: rdata_d = ot_lim_q[1];
				temp_alarm_pkg::REG_LOCAL_OT_LIMIT: rdata_d = ot_lim_q[0];
				temp_alarm_pkg::REG_OT_HYST: rdata_d = hyst_q;
				default: rdata_d = 8'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			config_q <= temp_alarm_pkg::RST_CONFIG;
			for (int i = 0; i < 2; i++) begin
				value_q[i] <= temp_alarm_pkg::RST_VALUE;
				high_q[i] <= temp_alarm_pkg::RST_HIGH_LIMIT;
				low_q[i] <= temp_alarm_pkg::RST_LOW_LIMIT;
				ot_lim_q[i] <= temp_alarm_pkg::RST_OT_LIMIT;
			end
			hyst_q <= temp_alarm_pkg::RST_OT_HYST;
			status_q <= 7'h00;
			cond_q <= 5'h00;
			ot_q <= 2'b00;
			ot2_q <= 2'b00;
			open_q <= 1'b0;
			alert_q <= 1'b0;
			serviced_q <= 1'b0;
			oneshot_q <= 1'b0;
			eval_q <= 1'b0;
			timer_q <= 32'h0;
			cv_q <= CV_IDLE;
			adc_req_q <= '0;
			reg_rdata_q <= 8'h00;
			alarm_oe_q <= 1'b0;
			overtemp_out_oe_q <= 1'b0;
		end else begin
			config_q <= config_d;
			value_q <= value_d;
			high_q <= high_d;
			low_q <= low_d;
			ot_lim_q <= ot_lim_d;
			hyst_q <= hyst_d;
			status_q <= status_d;
			cond_q <= cond_d;
			ot_q <= ot_d;
			ot2_q <= ot2_d;
			open_q <= open_d;
			alert_q <= alert_d;
			serviced_q <= serviced_d;
			oneshot_q <= oneshot_d;
			eval_q <= eval_d;
			timer_q <= timer_d;
			cv_q <= cv_d;
			adc_req_q <= adc_req_d;
			reg_rdata_q <= rdata_d;
			alarm_oe_q <= alarm_oe_d;
			overtemp_out_oe_q <= overtemp_out_oe_d;
		end
	end

endmodule
`default_nettype wire

/* File: bench/temp_alarm_interrupt_logic_assertions.sv */
// Checker of pin levels, converter sequencing and alarm release at the block's ports
`timescale 1ns/1ps
`default_nettype none
module temp_alarm_checker #(
	parameter int CONV_INTERVAL = 200
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Register port and converter
	input wire temp_alarm_pkg::reg_request_type reg_req,
	input wire temp_alarm_pkg::adc_request_type adc_req_q,
	input wire temp_alarm_pkg::adc_result_type adc_res,
	// Open-drain pins
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic alarm_o,
	input wire logic alarm_oe_q,
	input wire logic overtemp_out_o,
	input wire logic overtemp_out_oe_q
);
	logic [7:0] cfg_q, cfg_d;
	logic [2:0] ev_q, ev_d;
	logic os_q, os_d, rel_q, rel_d, cfg_wr, os_wr, st_rd;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	// ----------------------------------------------------------------
	// Shadow of config, one-shot, release permission and event age
	// ----------------------------------------------------------------
	// Release permission only counts while the pin is low, so a stale read cannot excuse it
	always_comb begin
		cfg_wr = reg_req.wr && reg_req.addr == temp_alarm_pkg::REG_CONFIG;
		os_wr = reg_req.wr && reg_req.addr == temp_alarm_pkg::REG_ONE_SHOT;
		st_rd = reg_req.rd && reg_req.addr == temp_alarm_pkg::REG_STATUS;
		cfg_d = cfg_wr ? reg_req.wdata : cfg_q;
		os_d = !cfg_wr && !(adc_res.done && adc_res.chan) && (os_q || (os_wr && cfg_q[6]));
		rel_d = alarm_oe_q && (rel_q || cfg_wr || st_rd);
		ev_d = (adc_res.done || reg_req.wr) ? 3'h0 : ev_q + {2'h0, ev_q != 3'h7};
	end
	// Shadow registers
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			cfg_q <= 8'h00;
			os_q <= 1'b0;
			rel_q <= 1'b0;
			ev_q <= 3'h7;
		end else begin
			cfg_q <= cfg_d;
			os_q <= os_d;
			rel_q <= rel_d;
			ev_q <= ev_d;
		end
	end

	property p_pins;
		alarm_o == 1'b0 && overtemp_out_o == 1'b0 && sda_o == 1'b0;
	endproperty
	a_pins: assert property (p_pins) else $error("pin drive level not low");
	property p_pair;
		adc_res.done && adc_res.chan == temp_alarm_pkg::CH_LOCAL |->
			##[1:2] adc_req_q.start && adc_req_q.chan == temp_alarm_pkg::CH_REMOTE;
	endproperty
	a_pair: assert property (p_pair) else $error("remote start missing");
	property p_oneshot;
		os_wr && cfg_q[6] |-> ##[1:3] adc_req_q.start && !adc_req_q.chan;
	endproperty
	a_oneshot: assert property (p_oneshot) else $error("one-shot did not start");
	property p_standby;
		cfg_q[6] && $past(cfg_q[6]) && !os_q |-> !adc_req_q.start;
	endproperty
	a_standby: assert property (p_standby) else $error("start in standby");
	property p_cause;
		$changed(overtemp_out_oe_q) || $rose(alarm_oe_q) |-> ev_q <= 3'h5;
	endproperty
	a_cause: assert property (p_cause) else $error("pin moved without evaluation");
	property p_release;
		$fell(alarm_oe_q) && !cfg_q[5] |-> rel_q;
	endproperty
	a_release: assert property (p_release) else $error("alarm freed early");
	property p_ack;
		sda_oe |-> alarm_oe_q;
	endproperty
	a_ack: assert property (p_ack) else $error("data driven without alarm");
	property p_mask;
		cfg_q[7] && !cfg_q[5] && $past(cfg_q[7], 3) && !$past(cfg_q[5], 3) |-> !alarm_oe_q;
	endproperty
	a_mask: assert property (p_mask) else $error("masked alarm driven");
	// Main scenarios reached
	c_alarm: cover property ($rose(alarm_oe_q));
	c_ot_free: cover property ($fell(overtemp_out_oe_q));
	c_reply: cover property ($rose(sda_oe));
endmodule
bind temp_alarm_interrupt_logic temp_alarm_checker #(.CONV_INTERVAL(CONV_INTERVAL)) u_chk (
	.clk_sys, .nrst, .reg_req, .adc_req_q, .adc_res, .sda_o, .sda_oe,
	.alarm_o, .alarm_oe_q, .overtemp_out_o, .overtemp_out_oe_q);
`default_nettype wire

/* File: bench/smbus_host.sv */
// Serial-bus master model that services alerts with alert response reads
`timescale 1ns/1ps
`default_nettype none
module smbus_host (
	// Data wire level
	input wire logic sda_w,
	// Clock level and data pull-down
	output logic scl,
	output logic sda_low
);
	localparam real QTR = 31.25;
	// Reply of a competing responder; zero bits pull the line low
	logic [7:0] rival = 8'hFF;
	// Clock parked high outside frames, data released
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// One clock pulse; data only moves while the clock is low
	task automatic bit_x(input logic b, output logic r);
		sda_low = !b;
		#QTR scl = 1'b1;
		#QTR r = sda_w;
		#QTR scl = 1'b0;
		#QTR;
	endtask
	// Start, response address read, one byte, no-acknowledge, stop
	task automatic alert_response_addr(output logic [7:0] data, output logic ack);
		logic r;
		logic [7:0] a;
		a = {temp_alarm_pkg::ALERT_RESPONSE_ADDR, 1'b1};
		sda_low = 1'b1;
		#QTR scl = 1'b0;
		#QTR;
		for (int i = 7; i >= 0; i--) bit_x(a[i], r);
		bit_x(1'b1, r);
		ack = !r;
		for (int i = 7; i >= 0; i--) bit_x(rival[i], data[i]);
		bit_x(1'b1, r);
		sda_low = 1'b1;
		#QTR scl = 1'b1;
		#QTR sda_low = 1'b0;
		#(2 * QTR);
	endtask
endmodule
`default_nettype wire

/* File: bench/temp_alarm_interrupt_logic_bench.sv */
// Bench: register tasks, converter model and alert service scenarios
`timescale 1ns/1ps
`default_nettype none
module temp_alarm_interrupt_logic_bench;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	temp_alarm_pkg::reg_request_type reg_req = '0;
	temp_alarm_pkg::adc_request_type adc_req_q;
	temp_alarm_pkg::adc_result_type adc_res = '0;
	logic [7:0] reg_rdata_q, rv, temp_v [2];
	logic [3:0] cnt = 4'h0;
	logic open_cmp = 1'b0;
	logic ch = 1'b0;
	logic scl, sda_low, sda_o, sda_oe, alarm_o, alarm_oe_q, ot_o, ot_oe_q, ack;
	int n_mismatch = 0, samples_checked = 0, n_start = 0, n_abort = 0, snap;
	wire logic sda_w = !(sda_oe || sda_low);

	// 250 MHz system clock
	always #2 clk_sys = !clk_sys;
	temp_alarm_interrupt_logic #(.CONV_INTERVAL(200)) u_dut (
		.clk_sys(clk_sys), .nrst(nrst), .reg_req(reg_req), .reg_rdata_q(reg_rdata_q),
		.adc_req_q(adc_req_q), .adc_res(adc_res), .open_cmp_i(open_cmp), .scl_i(scl),
		.sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .alarm_o(alarm_o),
		.alarm_oe_q(alarm_oe_q), .overtemp_out_o(ot_o), .overtemp_out_oe_q(ot_oe_q));
	smbus_host u_host (.sda_w(sda_w), .scl(scl), .sda_low(sda_low));

	// Converter model; idle result lines carry junk so stale values never match
	always @(posedge clk_sys) begin
		if (adc_req_q.start === 1'b1) begin
			cnt <= 4'h6;
			ch <= adc_req_q.chan;
			n_start <= n_start + 1;
		end else if (adc_req_q.abort === 1'b1) begin
			cnt <= 4'h0;
			n_abort <= n_abort + 1;
		end else if (cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
		end
		adc_res <= (cnt == 4'h1) ? {1'b1, ch, temp_v[ch]} : {1'b0, !ch, ~temp_v[ch]};
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys) reg_req <= '{1'b1, 1'b0, a, d};
		@(posedge clk_sys) reg_req <= '0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
		@(posedge clk_sys) reg_req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk_sys) reg_req <= '0;
		#1 chk(reg_rdata_q & m, exp);
	endtask
	// Waits for n completed remote conversions, then for the outputs to settle
	task automatic wait_conv(input int n);
		int k;
		k = 0;
		for (int i = 0; i < 3000 && k < n; i++) begin
			@(posedge clk_sys);
			if (adc_res.done === 1'b1 && adc_res.chan === 1'b1) k++;
		end
		if (k < n) begin
			n_mismatch++;
			summarize();
		end
		repeat (4) @(posedge clk_sys);
		#1;
	endtask
	// Status read, then up to three response reads while the line stays low
	task automatic clear_alarm();
		rd(8'h02, 8'h00, 8'h00);
		for (int i = 0; i < 3 && alarm_oe_q === 1'b1; i++) u_host.alert_response_addr(rv, ack);
		chk({7'h00, alarm_oe_q}, 8'h00);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		temp_v[0] = 8'h30;
		temp_v[1] = 8'h20;
		repeat (12) @(posedge clk_sys);
		nrst <= 1'b1;
		rd(8'h10, 8'h55, 8'hFF);
		rd(8'h11, 8'h55, 8'hFF);
		rd(8'h12, 8'h0A, 8'hFF);
		rd(8'h08, 8'h00, 8'hFF);
		wait_conv(2);
		rd(8'h00, 8'h30, 8'hFF);
		chk({6'h00, alarm_oe_q, ot_oe_q}, 8'h00);
		// Remote over its high and overtemperature limits
		temp_v[1] = 8'h60;
		wait_conv(2);
		chk({6'h00, alarm_oe_q, ot_oe_q}, 8'h03);
		rd(8'h02, 8'h12, 8'h7F);
		u_host.alert_response_addr(rv, ack);
		chk(rv, {7'h4C, 1'b1});
		chk({6'h00, ack, alarm_oe_q}, 8'h03);
		// Lower address on the shared line: our reply must back off
		u_host.rival = 8'h93;
		u_host.alert_response_addr(rv, ack);
		u_host.rival = 8'hFF;
		chk(rv, 8'h93);
		// Hysteresis boundary: one above the release level holds, the level frees
		temp_v[1] = 8'h4C;
		wait_conv(2);
		chk({7'h00, ot_oe_q}, 8'h01);
		temp_v[1] = 8'h4B;
		wait_conv(2);
		chk({7'h00, ot_oe_q}, 8'h00);
		clear_alarm();
		u_host.alert_response_addr(rv, ack);
		chk({7'h00, ack}, 8'h00);
		// Value equal to the low limit
		wr(8'h05, 8'h30);
		wait_conv(2);
		rd(8'h02, 8'h20, 8'h7F);
		wr(8'h05, 8'h00);
		wait_conv(2);
		clear_alarm();
		// Open sensor while masked, then unmasked
		@(posedge clk_sys) open_cmp <= 1'b1;
		wr(8'h03, 8'h80);
		wait_conv(2);
		rd(8'h02, 8'h04, 8'h7F);
		u_host.alert_response_addr(rv, ack);
		chk({6'h00, ack, alarm_oe_q}, 8'h00);
		wr(8'h03, 8'h00);
		wait_conv(2);
		chk({7'h00, alarm_oe_q}, 8'h01);
		@(posedge clk_sys) open_cmp <= 1'b0;
		wait_conv(2);
		clear_alarm();
		// Standby during a local conversion aborts it and stops further starts
		temp_v[0] = 8'h31;
		for (int i = 0; i < 400 && !(adc_req_q.start === 1'b1 && !adc_req_q.chan); i++) begin
			@(posedge clk_sys);
		end
		if (!(adc_req_q.start === 1'b1 && !adc_req_q.chan)) begin
			n_mismatch++;
			summarize();
		end
		snap = n_abort;
		wr(8'h03, 8'h40);
		repeat (3) @(posedge clk_sys);
		chk(8'(n_abort - snap), 8'h01);
		snap = n_start;
		repeat (500) @(posedge clk_sys);
		rd(8'h00, 8'h30, 8'hFF);
		chk(8'(n_start - snap), 8'h00);
		// One-shot converts both channels once, data ignored
		wr(8'h0F, 8'hA5);
		wait_conv(1);
		repeat (500) @(posedge clk_sys);
		chk(8'(n_start - snap), 8'h02);
		rd(8'h00, 8'h31, 8'hFF);
		// Limit written in standby compared at once
		wr(8'h04, 8'h20);
		repeat (8) @(posedge clk_sys);
		chk({7'h00, alarm_oe_q}, 8'h01);
		wr(8'h04, 8'h55);
		clear_alarm();
		// Second overtemperature role: mask ignored, hysteresis release
		wr(8'h03, 8'hE0);
		wr(8'h06, 8'h40);
		repeat (8) @(posedge clk_sys);
		chk({6'h00, alarm_oe_q, ot_oe_q}, 8'h02);
		wr(8'h06, 8'h55);
		repeat (8) @(posedge clk_sys);
		chk({7'h00, alarm_oe_q}, 8'h00);
		summarize();
	end
endmodule
`default_nettype wire
